// ### shared/sfpi_consts.vh
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH

`define SFPI_LANE_SINGLE  2'h0
`define SFPI_LANE_DUAL    2'h1
`define SFPI_LANE_QUAD    2'h2

`define SFPI_STEP_SINGLE  4'h1
`define SFPI_STEP_DUAL    4'h2
`define SFPI_STEP_QUAD    4'h4
`define SFPI_BYTE_BITS    4'h8

`define SFPI_PAGE_BYTES   9'h100
`define SFPI_ARRAY_PAGES  13'h1000
`define SFPI_SECTORS      11'h400
`define SFPI_BLOCKS       7'h40
`define SFPI_SEC_PER_BLK  11'h010

`define SFPI_ERASE_SECTOR 2'h0
`define SFPI_ERASE_32K    2'h1
`define SFPI_ERASE_64K    2'h2
`define SFPI_ERASE_CHIP   2'h3

`define SFPI_PAGES_SECTOR 13'h0010
`define SFPI_PAGES_32K    13'h0080
`define SFPI_PAGES_64K    13'h0100

`define SFPI_FIFO_WIDTH   9
`define SFPI_FIFO_DEPTH   8
`define SFPI_FIFO_AW      3
`define SFPI_IDLE_BYTE    8'hff

`endif

// ### core/sfpi_fifo.v
`timescale 1ns/1ns
`default_nettype none

module sfpi_fifo #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output reg  [W-1:0]  out_data_q,
  output reg           out_valid_q,
  input  wire          out_ready
);

  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          pop;

  assign in_ready = (cnt_q != D[AW:0]);
  assign push     = in_valid & in_ready;
  // Refill the output register whenever it is empty or being taken
  assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        out_data_q  <= mem[rd_q];
        out_valid_q <= 1'b1;
        rd_q        <= rd_q + 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // sfpi_fifo

`default_nettype wire

// ### core/sfpi_core.v
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_consts.vh"

module sfpi_core (
  input  wire        mclk,
  input  wire        rst,
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire        data_line_0_i,
  output reg         data_line_0_o,
  output reg         data_line_0_oe,
  input  wire        data_line_1_i,
  output reg         data_line_1_o,
  output reg         data_line_1_oe,
  input  wire        data_line_2_i,
  output reg         data_line_2_o,
  output reg         data_line_2_oe,
  input  wire        data_line_3_i,
  output reg         data_line_3_o,
  output reg         data_line_3_oe,
  input  wire        quad_enable_bit,
  input  wire [1:0]  status_lock_bits,
  input  wire        sector_granularity_bit,
  input  wire        top_bottom_select,
  input  wire        block_protect_field_2,
  input  wire        block_protect_field_1,
  input  wire        block_protect_field_0,
  input  wire [1:0]  lane_mode,
  input  wire        out_phase,
  input  wire        prog_phase,
  input  wire        busy_in,
  input  wire [7:0]  tx_data,
  input  wire        tx_valid,
  output reg         tx_ready_q,
  output wire [7:0]  rx_data,
  output wire        rx_first,
  output wire        rx_valid,
  input  wire        rx_ready,
  output reg         rx_overrun_q,
  output reg         armed_q,
  output reg         pause_q,
  output reg         standby_q,
  output reg         quad_refused_q,
  output reg         status_write_blocked_q,
  output reg         array_hw_protect_q,
  output reg         prot_valid_q,
  output reg  [9:0]  prot_lo_sector_q,
  output reg  [9:0]  prot_hi_sector_q,
  output reg  [8:0]  prog_count_q,
  input  wire [1:0]  erase_kind,
  input  wire [19:0] erase_addr,
  output reg  [11:0] erase_first_page_q,
  output reg  [12:0] erase_page_count_q
);

  wire [5:0] raw_pins;
  reg  [5:0] meta_q;
  reg  [5:0] sync_q;
  reg        sclk_prev_q;
  reg        cs_prev_q;

  assign raw_pins = {data_line_3_i, data_line_2_i, data_line_1_i,
                     data_line_0_i, sclk_pin, cs_n_pin};

  // Two-stage synchronisers; the link clock is only a sampled input
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_pins[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire       cs_n_s   = sync_q[0];
  wire       sclk_s   = sync_q[1];
  wire [3:0] lines_s  = sync_q[5:2];
  wire       sel      = ~cs_n_s;
  wire       sclk_up  = sclk_s & ~sclk_prev_q;
  wire       sclk_dn  = ~sclk_s & sclk_prev_q;
  // Edge regs reset low, so only a high level really seen can fall
  wire       cs_fall  = cs_prev_q & ~cs_n_s;
  wire       active   = sel & armed_q & ~pause_q;

  reg  [1:0] eff_mode;
  reg  [3:0] step;
  reg  [3:0] oe_pat;

  always @* begin
    eff_mode = lane_mode;
    if (lane_mode == `SFPI_LANE_QUAD && !quad_enable_bit) begin
      eff_mode = `SFPI_LANE_SINGLE;
    end
    case (eff_mode)
      `SFPI_LANE_DUAL: begin
        step   = `SFPI_STEP_DUAL;
        oe_pat = 4'h3;
      end
      `SFPI_LANE_QUAD: begin
        step   = `SFPI_STEP_QUAD;
        oe_pat = 4'hf;
      end
      default: begin
        step   = `SFPI_STEP_SINGLE;
        oe_pat = 4'h2;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b0;
      armed_q     <= 1'b0;
      standby_q   <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
      if (cs_fall) begin
        armed_q <= 1'b1;
      end
      standby_q <= ~sel & ~busy_in;
    end
  end

  // Pause changes only while the clock is low or on deselect, so a pin edge during a
  // high clock phase is simply picked up at the next low phase.
  always @(posedge mclk) begin
    if (rst) begin
      pause_q <= 1'b0;
    end else if (!sel) begin
      pause_q <= 1'b0;
    end else if (!sclk_s) begin
      pause_q <= armed_q & ~quad_enable_bit & ~lines_s[3];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      quad_refused_q <= 1'b0;
    end else begin
      quad_refused_q <= (lane_mode == `SFPI_LANE_QUAD) & ~quad_enable_bit;
    end
  end

  reg  [7:0] in_sr_q;
  reg  [3:0] in_cnt_q;
  reg        push_q;
  reg  [7:0] push_byte_q;
  reg        push_first_q;
  reg        first_q;
  reg  [7:0] in_next;
  reg  [3:0] in_sum;

  always @* begin
    case (eff_mode)
      `SFPI_LANE_DUAL: in_next = {in_sr_q[5:0], lines_s[1:0]};
      `SFPI_LANE_QUAD: in_next = {in_sr_q[3:0], lines_s[3:0]};
      default:         in_next = {in_sr_q[6:0], lines_s[0]};
    endcase
    in_sum = in_cnt_q + step;
  end

  // Receive side: the counters hold still while paused and are cleared
  // only by deselect or a completed byte, which keeps the byte position across a pause.
  always @(posedge mclk) begin
    if (rst) begin
      in_sr_q      <= 8'h00;
      in_cnt_q     <= 4'h0;
      push_q       <= 1'b0;
      push_byte_q  <= 8'h00;
      push_first_q <= 1'b0;
      first_q      <= 1'b0;
    end else begin
      push_q <= 1'b0;
      if (!sel) begin
        in_cnt_q <= 4'h0;
        first_q  <= 1'b1;
      end else if (active & sclk_up & ~out_phase) begin
        in_sr_q <= in_next;
        if (in_sum == `SFPI_BYTE_BITS) begin
          in_cnt_q     <= 4'h0;
          push_q       <= 1'b1;
          push_byte_q  <= in_next;
          push_first_q <= first_q;
          first_q      <= 1'b0;
        end else begin
          in_cnt_q <= in_sum;
        end
      end
    end
  end

  reg  [7:0] out_sr_q;
  reg  [3:0] out_cnt_q;
  reg  [3:0] out_bits_q;
  reg  [7:0] out_cur;
  reg  [7:0] out_shift;

  always @* begin
    out_cur = out_sr_q;
    if (out_cnt_q == 4'h0) begin
      out_cur = tx_valid ? tx_data : `SFPI_IDLE_BYTE;
    end
    case (eff_mode)
      `SFPI_LANE_DUAL: out_shift = {out_cur[5:0], 2'b00};
      `SFPI_LANE_QUAD: out_shift = {out_cur[3:0], 4'h0};
      default:         out_shift = {out_cur[6:0], 1'b0};
    endcase
  end

  // Transmit side: a new byte is taken from tx only on the falling edge
  // that needs it; with nothing offered the line shows all ones.
  always @(posedge mclk) begin
    if (rst) begin
      out_sr_q   <= 8'h00;
      out_cnt_q  <= 4'h0;
      out_bits_q <= 4'h0;
      tx_ready_q <= 1'b0;
    end else begin
      tx_ready_q <= 1'b0;
      if (!sel) begin
        out_cnt_q <= 4'h0;
      end else if (active & sclk_dn & out_phase) begin
        if (out_cnt_q == 4'h0) begin
          tx_ready_q <= tx_valid;
          out_cnt_q  <= `SFPI_BYTE_BITS - step;
        end else begin
          out_cnt_q  <= out_cnt_q - step;
        end
        out_sr_q <= out_shift;
        case (eff_mode)
          `SFPI_LANE_DUAL: out_bits_q <= {2'b00, out_cur[7:6]};
          `SFPI_LANE_QUAD: out_bits_q <= out_cur[7:4];
          default:         out_bits_q <= {2'b00, out_cur[7], 1'b0};
        endcase
      end
    end
  end

  // Pin drive: enables only in an output phase of a live selection
  always @(posedge mclk) begin
    if (rst) begin
      data_line_0_o  <= 1'b0;
      data_line_1_o  <= 1'b0;
      data_line_2_o  <= 1'b0;
      data_line_3_o  <= 1'b0;
      data_line_0_oe <= 1'b0;
      data_line_1_oe <= 1'b0;
      data_line_2_oe <= 1'b0;
      data_line_3_oe <= 1'b0;
    end else begin
      data_line_0_o <= out_bits_q[0];
      data_line_1_o <= out_bits_q[1];
      data_line_2_o <= out_bits_q[2];
      data_line_3_o <= out_bits_q[3];
      if (active & out_phase) begin
        data_line_0_oe <= oe_pat[0];
        data_line_1_oe <= oe_pat[1];
        data_line_2_oe <= oe_pat[2];
        data_line_3_oe <= oe_pat[3];
      end else begin
        data_line_0_oe <= 1'b0;
        data_line_1_oe <= 1'b0;
        data_line_2_oe <= 1'b0;
        data_line_3_oe <= 1'b0;
      end
    end
  end

  wire fifo_ready;

  // A host cannot be stalled mid-byte, so a full buffer drops the byte
  // and flags it; the flag is cleared by the next selection.
  always @(posedge mclk) begin
    if (rst) begin
      rx_overrun_q <= 1'b0;
      prog_count_q <= 9'h000;
    end else begin
      if (push_q & ~fifo_ready) begin
        rx_overrun_q <= 1'b1;
      end else if (cs_fall) begin
        rx_overrun_q <= 1'b0;
      end
      if (cs_fall) begin
        prog_count_q <= 9'h000;
      end else if (push_q & fifo_ready & prog_phase &
                   (prog_count_q != `SFPI_PAGE_BYTES)) begin
        prog_count_q <= prog_count_q + 9'h001;
      end
    end
  end

  sfpi_fifo #(
    .W  (`SFPI_FIFO_WIDTH),
    .D  (`SFPI_FIFO_DEPTH),
    .AW (`SFPI_FIFO_AW)
  ) u_rx_fifo (
    .clk         (mclk),
    .rst         (rst),
    .in_data     ({push_first_q, push_byte_q}),
    .in_valid    (push_q),
    .in_ready    (fifo_ready),
    .out_data_q  ({rx_first, rx_data}),
    .out_valid_q (rx_valid),
    .out_ready   (rx_ready)
  );

  wire [2:0]  bp_field = {block_protect_field_2, block_protect_field_1,
                          block_protect_field_0};
  wire [2:0]  bp_shift = bp_field - 3'h1;
  wire        wp_low   = ~lines_s[2] & ~quad_enable_bit;
  wire        hw_lock  = status_lock_bits[0] & wp_low;
  reg  [10:0] prot_size;

  always @* begin
    if (sector_granularity_bit) begin
      prot_size = 11'h001 << bp_shift;
    end else begin
      prot_size = `SFPI_SEC_PER_BLK << bp_shift;
    end
    if (prot_size > `SFPI_SECTORS) begin
      prot_size = `SFPI_SECTORS;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      status_write_blocked_q <= 1'b0;
      array_hw_protect_q     <= 1'b0;
      prot_valid_q           <= 1'b0;
      prot_lo_sector_q       <= 10'h000;
      prot_hi_sector_q       <= 10'h000;
    end else begin
      status_write_blocked_q <= hw_lock | status_lock_bits[1];
      prot_valid_q           <= (bp_field != 3'h0);
      array_hw_protect_q     <= (bp_field != 3'h0) & hw_lock;
      if (top_bottom_select) begin
        prot_lo_sector_q <= 10'h000;
        prot_hi_sector_q <= prot_size[9:0] - 10'h001;
      end else begin
        prot_lo_sector_q <= 10'h000 - prot_size[9:0];
        prot_hi_sector_q <= 10'h3ff;
      end
    end
  end

  reg [12:0] erase_pages;

  always @* begin
    case (erase_kind)
      `SFPI_ERASE_SECTOR: erase_pages = `SFPI_PAGES_SECTOR;
      `SFPI_ERASE_32K:    erase_pages = `SFPI_PAGES_32K;
      `SFPI_ERASE_64K:    erase_pages = `SFPI_PAGES_64K;
      default:            erase_pages = `SFPI_ARRAY_PAGES;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      erase_first_page_q <= 12'h000;
      erase_page_count_q <= 13'h0000;
    end else begin
      erase_page_count_q <= erase_pages;
      erase_first_page_q <= erase_addr[19:8] &
                            ~(erase_pages[11:0] - 12'h001);
    end
  end

endmodule // sfpi_core

`default_nettype wire

// ### test/sfpi_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sfpi_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cs_n_pin,
  input wire logic        quad_enable_bit,
  input wire logic [1:0]  status_lock_bits,
  input wire logic        out_phase,
  input wire logic        busy_in,
  input wire logic [1:0]  erase_kind,
  input wire logic        data_line_0_oe,
  input wire logic        data_line_1_oe,
  input wire logic        data_line_2_oe,
  input wire logic        data_line_3_oe,
  input wire logic        armed_q,
  input wire logic        pause_q,
  input wire logic        standby_q,
  input wire logic        status_write_blocked_q,
  input wire logic [8:0]  prog_count_q,
  input wire logic [12:0] erase_page_count_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [3:0] oe = {data_line_3_oe, data_line_2_oe, data_line_1_oe, data_line_0_oe};
  wire logic       qe_open = quad_enable_bit & ~status_lock_bits[1];
  function automatic logic [12:0] pages(input logic [1:0] k);
    return k == 2'h3 ? 13'h1000 : k == 2'h2 ? 13'h0100 : k == 2'h1 ? 13'h0080 : 13'h0010;
  endfunction
  a_desel_lines_off: assert property (cs_n_pin [*5] |-> oe == 4'h0)
    else $error("drive while deselected");
  a_rx_no_drive: assert property (!out_phase [*6] |-> oe == 4'h0)
    else $error("drive while receiving");
  a_pause_quiet: assert property (pause_q && $past(pause_q) |-> oe == 4'h0)
    else $error("drive during pause");
  a_qe_no_pause: assert property (quad_enable_bit [*6] |-> !pause_q)
    else $error("pause with quad on");
  a_qe_no_wp: assert property (qe_open [*3] |-> !status_write_blocked_q)
    else $error("pin lock with quad on");
  a_lock_blocks: assert property ((status_lock_bits[1] && !rst) [*3] |-> status_write_blocked_q)
    else $error("lock ignored");
  a_prog_cap: assert property (prog_count_q <= 9'h100)
    else $error("page count over");
  a_erase_pages: assert property (!$past(rst) |-> erase_page_count_q == pages($past(erase_kind)))
    else $error("erase size wrong");
  a_arm_on_fall: assert property ($rose(armed_q) |-> !cs_n_pin)
    else $error("armed without select");
  a_busy_no_stby: assert property ((busy_in && !rst) [*2] |-> !standby_q)
    else $error("standby while busy");
  a_idle_stby: assert property ((cs_n_pin && !busy_in && !rst) [*6] |-> standby_q)
    else $error("no standby when idle");
  c_pause: cover property (pause_q);
  c_drive: cover property (data_line_1_oe);
  c_full_page: cover property (prog_count_q == 9'h100);
endmodule // sfpi_monitor
bind sfpi_core sfpi_monitor mon_u (.*);
`default_nettype wire

// ### test/sfpi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfpi_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] line,
  output var  logic       cs_n,
  output var  logic       sclk,
  output var  logic [3:0] d_o,
  output var  logic [3:0] d_oe
);
  initial {cs_n, sclk, d_o, d_oe} = 10'h2fd;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic set_wp(input logic v);
    d_o[2] <= v;
  endtask
  // Idle level at the select edges picks clock mode 0 or 3
  task automatic sel(input logic lvl, input logic on);
    sclk <= lvl;
    cyc(4);
    cs_n <= !on;
    cyc(8);
  endtask
  task automatic xfer(input int w, input logic [7:0] b, input int hp, input int ps,
                      input logic [3:0] oe, output logic [7:0] r);
    logic [3:0] nv;
    int         i;
    for (i = 0; i < 8 / w; i++) begin
      nv = 4'((b >> (8 - w * (i + 1))) & ((1 << w) - 1));
      if (w < 4) nv[3:2] = 2'h3;
      sclk <= 1'b0;
      d_o <= nv;
      d_oe <= oe;
      cyc(hp);
      if (i == ps) begin
        // Pause taken with the clock low; the junk pulses must not count
        d_o <= {1'b0, ~nv[2:0]};
        repeat (2) begin
          cyc(hp);
          sclk <= 1'b1;
          cyc(hp);
          sclk <= 1'b0;
        end
        cyc(hp);
        d_o <= nv;
        cyc(hp);
      end
      r = {r[6:0], line[1]};
      sclk <= 1'b1;
      cyc(hp);
    end
  endtask
endmodule // sfpi_host_model
`default_nettype wire

// ### test/serial_flash_pin_interface_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_pin_interface_test;
  logic        mclk, rst, quad_enable_bit, sector_granularity_bit, top_bottom_select;
  logic        busy_in, out_phase, prog_phase, tx_valid, rx_ready, stall, keep, fst;
  logic        block_protect_field_2, block_protect_field_1, block_protect_field_0;
  logic [1:0]  status_lock_bits, lane_mode, erase_kind;
  logic [7:0]  tx_data, sd, rs, r;
  logic [19:0] erase_addr;
  logic [8:0]  exq[$];
  int          errors, n_checks, i, sz, pc, nt;
  wire logic        cs_n_pin, sclk_pin, tx_ready_q, rx_first, rx_valid, rx_overrun_q;
  wire logic        armed_q, pause_q, standby_q, quad_refused_q, status_write_blocked_q;
  wire logic        array_hw_protect_q, prot_valid_q;
  wire logic [3:0]  h_o, h_oe, d_o, d_oe, ln;
  wire logic [7:0]  rx_data;
  wire logic [9:0]  prot_lo_sector_q, prot_hi_sector_q;
  wire logic [8:0]  prog_count_q;
  wire logic [11:0] erase_first_page_q;
  wire logic [12:0] erase_page_count_q;
  // Released lines read high, as the board pull-ups make them
  assign ln = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe);
  sfpi_host_model hu (.mclk(mclk), .line(ln), .cs_n(cs_n_pin), .sclk(sclk_pin), .d_o(h_o),
                      .d_oe(h_oe));
  sfpi_core dut_u (.*,
    .data_line_0_i(ln[0]), .data_line_0_o(d_o[0]), .data_line_0_oe(d_oe[0]),
    .data_line_1_i(ln[1]), .data_line_1_o(d_o[1]), .data_line_1_oe(d_oe[1]),
    .data_line_2_i(ln[2]), .data_line_2_o(d_o[2]), .data_line_2_oe(d_oe[2]),
    .data_line_3_i(ln[3]), .data_line_3_o(d_o[3]), .data_line_3_oe(d_oe[3]));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic sb(input int w, input int ps);
    sd = nx(sd);
    if (keep) exq.push_back({fst, sd});
    fst = 1'b0;
    hu.xfer(w, sd, 4, ps, w == 1 ? 4'hd : 4'hf, r);
  endtask
  task automatic sel(input logic lvl);
    fst = 1'b1;
    hu.sel(lvl, 1'b1);
  endtask
  task automatic drain;
    for (i = 0; i < 500 && exq.size() > 0; i++) hu.cyc(1);
    chk(exq.size(), 0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #600000;
    errors++;
    finish_test;
  end
  always @(posedge mclk) begin
    rs <= nx(rs);
    rx_ready <= !stall && rs[0];
    if (tx_ready_q) nt++;
    if (rx_valid && rx_ready)
      chk({rx_first, rx_data}, exq.size() ? {4'h0, exq.pop_front()} : 13'h1fff);
  end
  initial begin
    rst = 1'b1;
    {quad_enable_bit, sector_granularity_bit, top_bottom_select, busy_in} = 4'h0;
    {out_phase, prog_phase, tx_valid, stall, rx_ready, fst} = 6'h0;
    {block_protect_field_2, block_protect_field_1, block_protect_field_0} = 3'h0;
    {status_lock_bits, lane_mode, erase_kind, tx_data, erase_addr} = 34'h0;
    {keep, sd, rs, errors, n_checks} = {1'b1, 8'h4b, 8'h4b, 32'd0, 32'd0};
    nt = 0;
    hu.cyc(8);
    rst <= 1'b0;
    hu.cyc(6);
    chk(armed_q, 1'b0);
    chk(standby_q, 1'b1);
    busy_in <= 1'b1;
    hu.cyc(4);
    chk(standby_q, 1'b0);
    busy_in <= 1'b0;
    lane_mode <= 2'h2;
    sel(1'b0);
    chk(armed_q, 1'b1);
    repeat (3) sb(1, 8);
    sb(1, 3);
    chk(quad_refused_q, 1'b1);
    hu.sel(1'b0, 1'b0);
    drain;
    hu.sel(1'b0, 1'b1);
    rst <= 1'b1;
    hu.cyc(8);
    rst <= 1'b0;
    keep = 1'b0;
    sb(1, 8);
    chk(armed_q, 1'b0);
    keep = 1'b1;
    hu.sel(1'b1, 1'b0);
    quad_enable_bit <= 1'b1;
    lane_mode <= 2'h1;
    sel(1'b1);
    repeat (2) sb(2, 8);
    lane_mode <= 2'h2;
    repeat (2) sb(4, 8);
    hu.sel(1'b1, 1'b0);
    {quad_enable_bit, lane_mode} <= 3'h0;
    sd = nx(sd);
    tx_data <= sd;
    {tx_valid, out_phase} <= 2'h3;
    sel(1'b1);
    hu.xfer(1, 8'hff, 8, 8, 4'hd, r);
    chk(r, tx_data);
    chk(nt, 1);
    out_phase <= 1'b0;
    hu.sel(1'b1, 1'b0);
    stall <= 1'b1;
    sel(1'b0);
    // Eight words in the buffer plus one in its output register
    repeat (9) sb(1, 8);
    keep = 1'b0;
    sb(1, 8);
    keep = 1'b1;
    hu.cyc(6);
    chk(rx_overrun_q, 1'b1);
    hu.sel(1'b0, 1'b0);
    stall <= 1'b0;
    drain;
    prog_phase <= 1'b1;
    sel(1'b0);
    repeat (257) sb(1, 8);
    hu.cyc(6);
    chk(prog_count_q, 9'h100);
    prog_phase <= 1'b0;
    hu.sel(1'b0, 1'b0);
    status_lock_bits <= 2'h1;
    for (i = 0; i < 32; i++) begin
      {top_bottom_select, sector_granularity_bit, block_protect_field_2,
       block_protect_field_1, block_protect_field_0} <= i[4:0];
      hu.set_wp(i[0]);
      hu.cyc(6);
      chk(prot_valid_q, i[2:0] != 3'h0);
      chk(array_hw_protect_q, i[2:0] != 3'h0 && !i[0]);
      if (i[2:0] != 3'h0) begin
        sz = (i[3] ? 1 : 16) << (i[2:0] - 1);
        if (sz > 1024) sz = 1024;
        chk(prot_lo_sector_q, i[4] ? 0 : 1024 - sz);
        chk(prot_hi_sector_q, i[4] ? sz - 1 : 1023);
      end
    end
    for (i = 0; i < 16; i++) begin
      {quad_enable_bit, status_lock_bits} <= i[3:1];
      hu.set_wp(i[0]);
      hu.cyc(6);
      chk(status_write_blocked_q, status_lock_bits[1]
          | (status_lock_bits[0] & !i[0] & !quad_enable_bit));
    end
    {quad_enable_bit, status_lock_bits} <= 3'h0;
    hu.set_wp(1'b1);
    for (i = 0; i < 4; i++) begin
      sd = nx(sd);
      erase_kind <= i[1:0];
      erase_addr <= {sd[3:0], nx(sd), sd};
      hu.cyc(3);
      pc = i == 0 ? 16 : i == 1 ? 128 : i == 2 ? 256 : 4096;
      chk(erase_page_count_q, pc);
      chk(erase_first_page_q, erase_addr[19:8] & ~(pc - 1));
    end
    drain;
    finish_test;
  end
endmodule // serial_flash_pin_interface_test
`default_nettype wire
